//--- mbd_parity_ram.sv
// ****************************************************************
// Shared constants
// ****************************************************************
package mbd_pkg;
    // Bus geometry
    localparam int ADDR_W     = 28;
    localparam int DATA_W     = 32;
    localparam int LANES      = 4;
    localparam int BYTE_W     = 8;
    localparam int WADDR_W    = 20;
    localparam int WORD_LSB   = 2;
    // Decode fields: 4-Mbyte segment, 64-Mbyte region, ignored upper lines
    localparam int SEG_LSB    = 22;
    localparam int SEG_W      = 4;
    localparam int LOW_SEG_W  = 2;
    localparam int REGION_W   = 2;
    localparam int SEL_W      = REGION_W + SEG_W;
    // Switch bundle: {ext, parity, region hi, region lo, segment, jumper a, jumper b}
    localparam int SW_W       = 10;
    localparam logic [SW_W-1:0] SW_RESET = 10'h3C3;
    localparam int SWB_EXT    = 9;
    localparam int SWB_PAR    = 8;
    localparam int SWB_REG    = 6;
    localparam int SWB_SEG    = 2;
    localparam int SWB_JA     = 1;
    localparam int SWB_JB     = 0;
    // AXI4-Lite map
    localparam int AXI_AW     = 8;
    localparam logic [AXI_AW-1:0] REG_STATUS   = 8'h00;
    localparam logic [AXI_AW-1:0] REG_MASK     = 8'h04;
    localparam logic [AXI_AW-1:0] REG_CONFIG   = 8'h08;
    localparam logic [AXI_AW-1:0] REG_ERR_ADDR = 8'h0C;
    localparam logic [AXI_AW-1:0] REG_ERR_CNT  = 8'h10;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Status bits
    localparam int ST_W       = 2;
    localparam int ST_FAST    = 0;
    localparam int ST_VME     = 1;
    localparam int CNT_W      = 16;
    typedef enum logic [1:0] {
        MBD_IDLE,
        MBD_LATCH,
        MBD_ACCESS,
        MBD_FETCH
    } mbd_state_t;
endpackage : mbd_pkg

`timescale 1ns/1ps

// ****************************************************************
// Parity store: one bit per byte lane per word, registered read
// ****************************************************************
module mbd_parity_ram (
    input  wire logic                        ref_clk,
    input  wire logic                        ce,
    input  wire logic                        we,
    input  wire logic [mbd_pkg::WADDR_W-1:0] addr,
    input  wire logic [mbd_pkg::LANES-1:0]   wmask,
    input  wire logic [mbd_pkg::LANES-1:0]   wdata,
    output logic      [mbd_pkg::LANES-1:0]   rdata
);
    import mbd_pkg::*;

    // One array per lane so each has a single writer; untouched lanes keep parity
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            logic lane_mem [0:(1<<WADDR_W)-1];
            // Read data always from a register
            always_ff @(posedge ref_clk) begin
                if (ce) begin
                    if (we && wmask[g]) begin
                        lane_mem[addr] <= wdata[g];
                    end
                    rdata[g] <= lane_mem[addr];
                end
            end
        end
    endgenerate
endmodule : mbd_parity_ram

//--- mbd_decode_parity.sv
`timescale 1ns/1ps

module mbd_decode_parity (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        ce,
    // Switches and jumpers, asynchronous
    input  wire logic                        ext_addr_disable_switch,
    input  wire logic                        parity_check_switch,
    input  wire logic                        region_select_hi,
    input  wire logic                        region_select_lo,
    input  wire logic [mbd_pkg::SEG_W-1:0]   segment_selector,
    input  wire logic                        latch_timing_jumper_a,
    input  wire logic                        latch_timing_jumper_b,
    // Fast memory bus, processor side
    input  wire logic                        fb_strobe,
    input  wire logic                        fb_write,
    input  wire logic [mbd_pkg::ADDR_W-1:0]  fb_addr,
    input  wire logic [mbd_pkg::LANES-1:0]   fb_byte_en,
    input  wire logic [mbd_pkg::DATA_W-1:0]  fb_wdata,
    output logic                             fb_ack,
    output logic                             fastbus_parity_error_n,
    // VMEbus side
    input  wire logic                        vme_strobe,
    input  wire logic                        vme_write,
    input  wire logic [mbd_pkg::ADDR_W-1:0]  vme_addr,
    input  wire logic [mbd_pkg::LANES-1:0]   vme_byte_en,
    input  wire logic [mbd_pkg::DATA_W-1:0]  vme_wdata,
    output logic                             vme_ack,
    output logic                             vme_berr_o,
    output logic                             vme_berr_oe,
    output logic      [mbd_pkg::DATA_W-1:0]  rd_data,
    // Data array outside this block
    output logic                             mem_we,
    output logic                             mem_rd,
    output logic      [mbd_pkg::WADDR_W-1:0] mem_addr,
    output logic      [mbd_pkg::LANES-1:0]   mem_be,
    output logic      [mbd_pkg::DATA_W-1:0]  mem_wdata,
    input  wire logic [mbd_pkg::DATA_W-1:0]  mem_rdata,
    // AXI4-Lite slave
    input  wire logic [mbd_pkg::AXI_AW-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [mbd_pkg::DATA_W-1:0]  s_axi_wdata,
    input  wire logic [mbd_pkg::LANES-1:0]   s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic      [1:0]                  s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [mbd_pkg::AXI_AW-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic      [mbd_pkg::DATA_W-1:0]  s_axi_rdata,
    output logic      [1:0]                  s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    output logic                             irq
);
    import mbd_pkg::*;

    // ****************************************************************
    // Switch synchroniser
    // ****************************************************************
    logic [SW_W-1:0] sw_meta;
    logic [SW_W-1:0] sw_sync;
    wire  [SW_W-1:0] sw_raw = {ext_addr_disable_switch, parity_check_switch,
                               region_select_hi, region_select_lo, segment_selector,
                               latch_timing_jumper_a, latch_timing_jumper_b};

    // Reset to factory settings, so decode is sane before the flops fill
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sw_meta <= SW_RESET;
            sw_sync <= SW_RESET;
        end else if (ce) begin
            sw_meta <= sw_raw;
            sw_sync <= sw_meta;
        end
    end

    // Configuration decode
    wire                ext_en     = ~sw_sync[SWB_EXT];
    wire                chk_en     = sw_sync[SWB_PAR];
    wire [REGION_W-1:0] region_sel = ~sw_sync[SWB_REG +: REGION_W];
    wire [SEG_W-1:0]    seg_sel    = sw_sync[SWB_SEG +: SEG_W];
    wire                mode_020   = sw_sync[SWB_JA] & sw_sync[SWB_JB];

    // ****************************************************************
    // Cycle sequencer
    // ****************************************************************
    mbd_state_t        state;
    logic              src_vme;
    logic              lat_write;
    logic [ADDR_W-1:0] lat_addr;
    logic [LANES-1:0]  lat_be;
    logic [DATA_W-1:0] lat_wdata;

    // Address match: full select with extended lines, low segment bits otherwise
    wire [SEL_W-1:0] ext_sel = lat_addr[ADDR_W-1:SEG_LSB];
    wire hit_ext = (ext_sel == {region_sel, seg_sel});
    wire hit_std = (lat_addr[SEG_LSB+LOW_SEG_W-1:SEG_LSB] == seg_sel[LOW_SEG_W-1:0]);
    wire hit     = ext_en ? hit_ext : hit_std;
    wire [WADDR_W-1:0] word_addr = lat_addr[WORD_LSB+WADDR_W-1:WORD_LSB];

    wire do_write = (state == MBD_ACCESS) && hit && lat_write;
    wire do_read  = (state == MBD_ACCESS) && hit && !lat_write;

    // Parity per lane: generated from write data, checked against memory
    logic [LANES-1:0] par_wdata;
    logic [LANES-1:0] par_rdata;
    logic [LANES-1:0] lane_bad;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_par
            assign par_wdata[g] = ~^lat_wdata[g*BYTE_W +: BYTE_W];
            assign lane_bad[g]  = lat_be[g] &&
                                  (par_rdata[g] != ~^mem_rdata[g*BYTE_W +: BYTE_W]);
        end
    endgenerate
    // Checking off masks the report only; storage is unaffected
    wire chk_fail = (state == MBD_FETCH) && chk_en && (|lane_bad);

    mbd_parity_ram u_par (
        .ref_clk (ref_clk),
        .ce      (ce),
        .we      (do_write),
        .addr    (word_addr),
        .wmask   (lat_be),
        .wdata   (par_wdata),
        .rdata   (par_rdata)
    );

    // State and latched request; a strobe outside idle is not taken
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= MBD_IDLE;
        end else if (ce) begin
            case (state)
                MBD_IDLE: begin
                    if (fb_strobe || vme_strobe) begin
                        state <= mode_020 ? MBD_ACCESS : MBD_LATCH;
                    end
                end
                MBD_LATCH:  state <= MBD_ACCESS;
                MBD_ACCESS: state <= do_read ? MBD_FETCH : MBD_IDLE;
                MBD_FETCH:  state <= MBD_IDLE;
                default:    state <= MBD_IDLE;
            endcase
        end
    end

    // Processor bus wins when both strobe together
    wire pick_vme = !fb_strobe;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            src_vme   <= 1'b0;
            lat_write <= 1'b0;
            lat_addr  <= '0;
            lat_be    <= '0;
            lat_wdata <= '0;
        end else if (ce) begin
            if (state == MBD_IDLE && (fb_strobe || vme_strobe)) begin
                src_vme   <= pick_vme;
                lat_write <= pick_vme ? vme_write : fb_write;
                lat_be    <= pick_vme ? vme_byte_en : fb_byte_en;
                lat_wdata <= pick_vme ? vme_wdata : fb_wdata;
                lat_addr  <= pick_vme ? vme_addr : fb_addr;
            end else if (state == MBD_LATCH) begin
                lat_addr  <= src_vme ? vme_addr : fb_addr;
            end
        end
    end

    // Bus outputs: one-cycle strobes, errors drive low for one cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fb_ack                 <= 1'b0;
            vme_ack                <= 1'b0;
            fastbus_parity_error_n <= 1'b1;
            vme_berr_o             <= 1'b0;
            vme_berr_oe            <= 1'b0;
            rd_data                <= '0;
            mem_we                 <= 1'b0;
            mem_rd                 <= 1'b0;
            mem_addr               <= '0;
            mem_be                 <= '0;
            mem_wdata              <= '0;
        end else if (ce) begin
            fb_ack                 <= (do_write || state == MBD_FETCH) && !src_vme;
            vme_ack                <= (do_write || state == MBD_FETCH) && src_vme;
            fastbus_parity_error_n <= !(chk_fail && !src_vme);
            vme_berr_oe            <= chk_fail && src_vme;
            mem_we                 <= do_write;
            mem_rd                 <= do_read;
            if (state == MBD_FETCH) begin
                rd_data <= mem_rdata;
            end
            if (state == MBD_ACCESS) begin
                mem_addr  <= word_addr;
                mem_be    <= lat_be;
                mem_wdata <= lat_wdata;
            end
        end
    end

    // ****************************************************************
    // Error capture and interrupt
    // ****************************************************************
    logic [ST_W-1:0]   status;
    logic [ST_W-1:0]   mask;
    logic [ADDR_W-1:0] err_addr;
    logic [CNT_W-1:0]  err_cnt;
    wire  [ST_W-1:0]   st_set = {chk_fail && src_vme, chk_fail && !src_vme};
    wire               wr_fire;
    wire  [AXI_AW-1:0] wr_addr;
    wire  [DATA_W-1:0] wr_data;
    wire  [ST_W-1:0]   st_clr = (wr_fire && wr_addr == REG_STATUS) ? wr_data[ST_W-1:0] : '0;
    wire  [ST_W-1:0]   next_status = (status & ~st_clr) | st_set;   // Set beats clear

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status   <= '0;
            mask     <= '0;
            err_addr <= '0;
            err_cnt  <= '0;
            irq      <= 1'b0;
        end else if (ce) begin
            status <= next_status;
            irq    <= |(next_status & mask);
            if (wr_fire && wr_addr == REG_MASK) begin
                mask <= wr_data[ST_W-1:0];
            end
            if (chk_fail) begin
                err_addr <= lat_addr;
                err_cnt  <= err_cnt + 1'b1;                  // Wraps; software diffs it
            end
        end
    end

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    logic [AXI_AW-1:0] aw_hold;
    logic [DATA_W-1:0] w_hold;
    assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_addr = aw_hold;
    assign wr_data = w_hold;
    wire wr_known = (aw_hold == REG_STATUS) || (aw_hold == REG_MASK);
    wire rd_known = (s_axi_araddr <= REG_ERR_CNT) && (s_axi_araddr[1:0] == 2'h0);
    logic [DATA_W-1:0] rd_mux;

    // Read selection
    always_comb begin
        rd_mux = '0;
        case (s_axi_araddr)
            REG_STATUS:   rd_mux[ST_W-1:0]   = status;
            REG_MASK:     rd_mux[ST_W-1:0]   = mask;
            REG_CONFIG:   rd_mux[SW_W-1:0]   = sw_sync;
            REG_ERR_ADDR: rd_mux[ADDR_W-1:0] = err_addr;
            REG_ERR_CNT:  rd_mux[CNT_W-1:0]  = err_cnt;
            default:      rd_mux             = '0;
        endcase
    end

    // Write channel: hold address and data, answer once both are in
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_hold       <= '0;
            w_hold        <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold       <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read channel: answer the cycle after the address is taken
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !ce);

    sequence s_start_020;
        state == MBD_IDLE && (fb_strobe || vme_strobe) && mode_020;
    endsequence
    sequence s_start_010;
        state == MBD_IDLE && (fb_strobe || vme_strobe) && !mode_020;
    endsequence
    sequence s_read_hit;
        state == MBD_ACCESS && hit && !lat_write;
    endsequence

    fast_error_line_a: assert property (chk_fail && !src_vme |=> !fastbus_parity_error_n)
        else $error("fast-bus parity error not driven");
    vme_error_line_a: assert property (chk_fail && src_vme |=> vme_berr_oe && fastbus_parity_error_n)
        else $error("bus error not driven on VME parity fault");
    check_off_quiet_a: assert property (state == MBD_FETCH && !chk_en |=> fastbus_parity_error_n && !vme_berr_oe)
        else $error("parity error reported with checking off");
    write_odd_a: assert property (do_write && lat_be[0] |-> ^{par_wdata[0], lat_wdata[7:0]})
        else $error("stored parity is not odd");
    std_decode_a: assert property (state == MBD_ACCESS && !ext_en &&
        lat_addr[SEG_LSB +: LOW_SEG_W] == seg_sel[LOW_SEG_W-1:0] |-> hit)
        else $error("upper lines not ignored");
    ext_region_a: assert property (state == MBD_ACCESS && ext_en &&
        lat_addr[ADDR_W-1 -: REGION_W] != region_sel |-> !hit)
        else $error("wrong region accepted");
    latch_020_a: assert property (s_start_020 |=> state == MBD_ACCESS)
        else $error("020 timing did not latch at strobe");
    latch_010_a: assert property (s_start_010 |=> state == MBD_LATCH ##1 state == MBD_ACCESS)
        else $error("010 timing did not delay latch");
    read_answer_a: assert property (s_read_hit |=> state == MBD_FETCH ##1 (fb_ack || vme_ack))
        else $error("read not answered after check");
endmodule : mbd_decode_parity

//--- mbd_mem_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Data array beside the block
// ****************************************************************
module mbd_mem_model (
    input  wire logic                        ref_clk,
    input  wire logic                        mem_we,
    input  wire logic                        mem_rd,
    input  wire logic [mbd_pkg::WADDR_W-1:0] mem_addr,
    input  wire logic [mbd_pkg::LANES-1:0]   mem_be,
    input  wire logic [mbd_pkg::DATA_W-1:0]  mem_wdata,
    input  wire logic [mbd_pkg::DATA_W-1:0]  flip,
    output logic      [mbd_pkg::DATA_W-1:0]  mem_rdata
);
    import mbd_pkg::*;
    logic [DATA_W-1:0] store [logic [WADDR_W-1:0]];
    logic [DATA_W-1:0] last = '0;
    logic [DATA_W-1:0] w;
    // Lane-wise write; unwritten words read as zero
    always @(posedge ref_clk) begin
        if (mem_we) begin
            w = store.exists(mem_addr) ? store[mem_addr] : '0;
            for (int i = 0; i < LANES; i++) begin
                if (mem_be[i]) w[BYTE_W*i +: BYTE_W] = mem_wdata[BYTE_W*i +: BYTE_W];
            end
            store[mem_addr] = w;
        end
        if (mem_rd) last <= mem_rdata;
    end
    // Outside a read the lines show no stale word, so a late sample fails
    always @(mem_rd, mem_addr, flip, last) begin
        if (mem_rd) mem_rdata = (store.exists(mem_addr) ? store[mem_addr] : '0) ^ flip;
        else mem_rdata = ~last;
    end
endmodule : mbd_mem_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
    import mbd_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic ref_clk = 1'h0, rst = 1'h1, ce = 1'h1, fb_strobe = 1'h0, vme_strobe = 1'h0;
    logic ext_addr_disable_switch = 1'h1, parity_check_switch = 1'h1;
    logic region_select_hi = 1'h1, region_select_lo = 1'h1, fb_write = 1'h0, vme_write = 1'h0;
    logic latch_timing_jumper_a = 1'h1, latch_timing_jumper_b = 1'h1;
    logic [SEG_W-1:0] segment_selector = '0;
    logic [ADDR_W-1:0] fb_addr = '0, vme_addr = '0, skew = '0;
    logic [LANES-1:0] fb_byte_en = 4'hF, vme_byte_en = 4'hF, s_axi_wstrb = 4'hF, mem_be;
    logic [DATA_W-1:0] fb_wdata = '0, vme_wdata = '0, s_axi_wdata = '0, flip = '0;
    logic [DATA_W-1:0] rd_data, mem_wdata, mem_rdata, s_axi_rdata;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, fb_ack, fastbus_parity_error_n;
    logic vme_ack, vme_berr_o, vme_berr_oe, mem_we, mem_rd, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [WADDR_W-1:0] mem_addr;
    int fails = 0, tests_run = 0;
    // Open-collector error line as the backplane sees it
    wire berr_n = vme_berr_oe ? vme_berr_o : 1'h1;
    always #5 ref_clk = ~ref_clk;
    mbd_decode_parity i_mbd_decode_parity (
        .ref_clk, .rst, .ce, .ext_addr_disable_switch, .parity_check_switch,
        .region_select_hi, .region_select_lo, .segment_selector,
        .latch_timing_jumper_a, .latch_timing_jumper_b, .fb_strobe, .fb_write, .fb_addr,
        .fb_byte_en, .fb_wdata, .fb_ack, .fastbus_parity_error_n, .vme_strobe, .vme_write,
        .vme_addr, .vme_byte_en, .vme_wdata, .vme_ack, .vme_berr_o, .vme_berr_oe, .rd_data,
        .mem_we, .mem_rd, .mem_addr, .mem_be, .mem_wdata, .mem_rdata, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .irq);
    mbd_mem_model i_mbd_mem_model (
        .ref_clk, .mem_we, .mem_rd, .mem_addr, .mem_be, .mem_wdata, .flip, .mem_rdata);
    // ****************************************************************
    // Access and compare tasks
    // ****************************************************************
    task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %0t word %h expected %h", $time, g, e);
        end
    endtask : chk_w
    task automatic chk_b(input logic g, input logic e);
        chk_w({31'h0, g}, {31'h0, e});
    endtask : chk_b
    // One memory cycle; skew spoils the address seen at the strobe edge only
    task automatic cyc(input bit v, input logic wr, input logic [27:0] a,
                       input logic [31:0] d, output logic h, output logic e);
        @(posedge ref_clk);
        fb_strobe <= !v; vme_strobe <= v; fb_write <= wr; vme_write <= wr;
        fb_addr <= a ^ skew; vme_addr <= a ^ skew; fb_wdata <= d; vme_wdata <= d;
        @(posedge ref_clk);
        fb_strobe <= 1'h0; vme_strobe <= 1'h0; fb_addr <= a; vme_addr <= a;
        h = 1'h0;
        e = 1'h0;
        repeat (6) begin
            @(negedge ref_clk);
            if ((v ? vme_ack : fb_ack) === 1'h1) begin
                h = 1'h1;
                e = v ? berr_n === 1'h0 : fastbus_parity_error_n === 1'h0;
            end
        end
    endtask : cyc
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw = 1, w = 1, b = 0;
        @(posedge ref_clk);
        s_axi_awaddr <= a; s_axi_awvalid <= 1'h1; s_axi_wdata <= d; s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!b) begin
            @(posedge ref_clk);
            if (aw && s_axi_awready === 1'h1) begin aw = 0; s_axi_awvalid <= 1'h0; end
            if (w && s_axi_wready === 1'h1) begin w = 0; s_axi_wvalid <= 1'h0; end
            if (s_axi_bvalid === 1'h1) begin b = 1; s_axi_bready <= 1'h0; r = s_axi_bresp; end
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar = 1, b = 0;
        @(posedge ref_clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        while (!b) begin
            @(posedge ref_clk);
            if (ar && s_axi_arready === 1'h1) begin ar = 0; s_axi_arvalid <= 1'h0; end
            if (s_axi_rvalid === 1'h1) begin
                b = 1; s_axi_rready <= 1'h0; d = s_axi_rdata; r = s_axi_rresp;
            end
        end
    endtask : axi_rd
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    // Hang guard, far beyond the few hundred cycles of the sequence
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end
    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        logic h, e;
        logic [31:0] d;
        logic [1:0] r;
        logic [27:0] base;
        repeat (20) @(posedge ref_clk);
        rst <= 1'h0;
        repeat (4) @(posedge ref_clk);
        axi_rd(REG_CONFIG, d, r);
        chk_w(d, {22'h0, SW_RESET});
        axi_rd(8'h20, d, r);
        chk_w({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_wr(REG_CONFIG, 32'h0, r);
        chk_w({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_wr(REG_MASK, 32'h3, r);
        cyc(0, 1, 28'hF000010, 32'h1234_5678, h, e);
        chk_b(h, 1'h1);
        cyc(1, 0, 28'h0000010, 32'h0, h, e);
        chk_b(h & !e, 1'h1);
        chk_w(rd_data, 32'h1234_5678);
        cyc(0, 0, 28'h0400010, 32'h0, h, e);
        chk_b(h, 1'h0);
        flip <= 32'h0000_0100;
        cyc(0, 0, 28'h0000010, 32'h0, h, e);
        chk_b(e, 1'h1);
        cyc(1, 0, 28'h0000010, 32'h0, h, e);
        chk_b(e, 1'h1);
        axi_rd(REG_STATUS, d, r);
        chk_w(d, 32'h3);
        chk_b(irq, 1'h1);
        axi_rd(REG_ERR_CNT, d, r);
        chk_w(d, 32'h2);
        axi_rd(REG_ERR_ADDR, d, r);
        chk_w(d, 32'h10);
        axi_wr(REG_MASK, 32'h0, r);
        // The level falls one edge after the mask lands; look once it has settled
        @(negedge ref_clk);
        chk_b(irq, 1'h0);
        axi_wr(REG_STATUS, 32'h3, r);
        axi_rd(REG_STATUS, d, r);
        chk_w(d, 32'h0);
        axi_wr(REG_MASK, 32'h3, r);
        parity_check_switch <= 1'h0;
        repeat (4) @(posedge ref_clk);
        cyc(0, 0, 28'h0000010, 32'h0, h, e);
        chk_b(h & !e & !irq, 1'h1);
        flip <= '0; parity_check_switch <= 1'h1; ext_addr_disable_switch <= 1'h0;
        // Every region, each with its own segment
        for (int i = 0; i < 4; i++) begin
            region_select_hi <= i[1]; region_select_lo <= i[0]; segment_selector <= 4'(4*i+3);
            base = {~i[1], ~i[0], 4'(4*i+3), 22'h0};
            repeat (4) @(posedge ref_clk);
            cyc(0, 1, base + 28'h8, {4'hA, base}, h, e);
            chk_b(h, 1'h1);
            cyc(1, 0, base + 28'h8, 32'h0, h, e);
            chk_w(rd_data, {4'hA, base});
            cyc(0, 0, base ^ 28'h4000008, 32'h0, h, e);
            chk_b(h, 1'h0);
        end
        ext_addr_disable_switch <= 1'h1; segment_selector <= 4'h0; latch_timing_jumper_b <= 1'h0;
        skew <= 28'h0400000;
        repeat (4) @(posedge ref_clk);
        cyc(0, 1, 28'h0000020, 32'hCAFE_F00D, h, e);
        chk_b(h, 1'h1);
        cyc(1, 0, 28'h0000020, 32'h0, h, e);
        chk_w(rd_data, 32'hCAFE_F00D);
        // Enable low must freeze the switch synchroniser
        ce <= 1'h0; parity_check_switch <= 1'h0;
        repeat (4) @(posedge ref_clk);
        ce <= 1'h1;
        axi_rd(REG_CONFIG, d, r);
        chk_w(d, {22'h0, 10'h3C2});
        end_sim();
    end
endmodule : testbench
